// ---- logic/acf_pkg.sv ----
// Shared constants for the sample clocking and tagged buffer block.
package acf_pkg;
  localparam int NCH      = 6;
  localparam int NGRP     = 2;
  localparam int GRP_SIZE = 3;
  localparam int NGEN     = 2;
  localparam int DATA_W   = 16;
  localparam int TAG_W    = 3;
  localparam int WORD_W   = DATA_W + TAG_W;
  localparam int HOST_W   = 32;
  localparam int FIFO_DEPTH = 65536;
  localparam int CNT_W    = 17;
  localparam int DIV_W    = 5;
  localparam logic [4:0] DIV_MIN = 5'h01;
  localparam logic [4:0] DIV_MAX = 5'h14;
  // One generator tick stands for eight generator periods, so that 38.4 MHz
  // fits under the 25 MHz system clock.
  localparam int GEN_PRE  = 8;
  localparam int OS16_DIV = 32;
  localparam int OS32_DIV = 64;
  localparam logic [2:0] OS16_LIM = 3'(OS16_DIV / GEN_PRE - 1);
  localparam logic [2:0] OS32_LIM = 3'(OS32_DIV / GEN_PRE - 1);
  localparam logic [1:0] SRC_GEN0 = 2'h0;
  localparam logic [1:0] SRC_GEN1 = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  // Input mode codes: 0 differential, 1 single-ended, 2 internal reference.
  // Range codes: 0 1.25 V, 1 2.5 V, 2 5 V, 3 10 V.
  localparam int NCO_W = 32;
  localparam longint CLK_HZ     = 25_000_000;
  localparam longint GEN_MIN_HZ = 19_200_000;
  localparam longint GEN_MAX_HZ = 38_400_000;
  localparam logic [31:0] TW_MIN =
    32'((((GEN_MIN_HZ / GEN_PRE) << NCO_W) + CLK_HZ - 1) / CLK_HZ);
  localparam logic [31:0] TW_MAX =
    32'(((GEN_MAX_HZ / GEN_PRE) << NCO_W) / CLK_HZ);
  localparam longint SETTLE_MS  = 20;
  localparam int     SETTLE_CYC = int'(SETTLE_MS * CLK_HZ / 1000);
  localparam int NFLG       = 5;
  localparam int FLG_THR    = 0;
  localparam int FLG_SETTLE = 1;
  localparam int FLG_DMA    = 3;
endpackage : acf_pkg

// ---- logic/acf_fifo_if.sv ----
// Push and pop signals between the control logic and the sample buffer.
`timescale 1ns/1ps
interface acf_fifo_if #(parameter int W = 19, parameter int CW = 17);
  logic          push_valid;
  logic          push_ready;
  logic [W-1:0]  push_word;
  logic          pop_req;
  logic          pop_valid;
  logic [W-1:0]  pop_word;
  logic [CW-1:0] level;
  modport ctrl  (output push_valid, push_word, pop_req,
                 input  push_ready, pop_valid, pop_word, level);
  modport store (input  push_valid, push_word, pop_req,
                 output push_ready, pop_valid, pop_word, level);
endinterface : acf_fifo_if

// ---- logic/acf_rate_gen.sv ----
// Programmable rate generator with settling indication.
`timescale 1ns/1ps
module acf_rate_gen #(
  parameter int SETTLE_CYC = acf_pkg::SETTLE_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        tw_wr,
  input  wire logic [31:0] tw_in,
  output logic             tick,
  output logic             settle_done
);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  logic [31:0]   tw_reg;
  logic [31:0]   tw_next;
  logic [31:0]   acc_reg;
  logic [32:0]   sum;
  logic [SW-1:0] settle_reg;

  // Out-of-range words are clamped rather than refused.
  always_comb begin
    if (tw_in < acf_pkg::TW_MIN) tw_next = acf_pkg::TW_MIN;
    else if (tw_in > acf_pkg::TW_MAX) tw_next = acf_pkg::TW_MAX;
    else tw_next = tw_in;
  end
  assign sum = {1'b0, acc_reg} + {1'b0, tw_reg};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tw_reg  <= 32'h0;
      acc_reg <= 32'h0;
      tick    <= 1'b0;
    end else begin
      if (tw_wr) tw_reg <= tw_next;
      acc_reg <= sum[31:0];
      tick    <= sum[32] && tw_reg != 32'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg  <= '0;
      settle_done <= 1'b0;
    end else begin
      settle_done <= 1'b0;
      if (tw_wr) settle_reg <= SW'(SETTLE_CYC);
      else if (settle_reg != '0) begin
        settle_reg <= settle_reg - SW'(1);
        settle_done <= settle_reg == SW'(1);
      end
    end
  end

  a_tw_range: assert property (@(posedge clock) disable iff (!rst_n)
    tw_reg == 32'h0 || (tw_reg >= acf_pkg::TW_MIN && tw_reg <= acf_pkg::TW_MAX))
    else $error("tuning word out of range");
  a_settle_wait: assert property (@(posedge clock) disable iff (!rst_n)
    tw_wr |=> !settle_done [*8])
    else $error("settling flagged too early");
endmodule : acf_rate_gen

// ---- logic/acf_sample_fifo.sv ----
// Tagged sample buffer with fill level count.
`timescale 1ns/1ps
module acf_sample_fifo #(
  parameter int DEPTH = acf_pkg::FIFO_DEPTH,
  parameter int W     = acf_pkg::WORD_W,
  parameter int CW    = acf_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  acf_fifo_if.store fp
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] level_reg;
  logic          do_push;
  logic          do_pop;

  assign fp.push_ready = level_reg != CW'(DEPTH);
  assign fp.level      = level_reg;
  assign do_push = fp.push_valid && fp.push_ready;
  assign do_pop  = fp.pop_req && level_reg != '0;

  always_ff @(posedge clock) begin
    if (do_push) mem[wr_ptr_reg] <= fp.push_word;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      level_reg    <= '0;
      fp.pop_valid <= 1'b0;
      fp.pop_word  <= '0;
    end else begin
      fp.pop_valid <= do_pop;
      if (do_push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (do_pop) begin
        rd_ptr_reg  <= rd_ptr_reg + AW'(1);
        fp.pop_word <= mem[rd_ptr_reg];
      end
      level_reg <= level_reg + CW'(do_push) - CW'(do_pop);
    end
  end

  a_level_track: assert property (@(posedge clock) disable iff (!rst_n)
    level_reg == $past(level_reg) + CW'($past(do_push)) - CW'($past(do_pop)))
    else $error("buffer level does not track pushes and pops");
endmodule : acf_sample_fifo

// ---- logic/acf_top.sv ----
// Sample clocking, sync, tagged buffer and DMA control for six channels.
`timescale 1ns/1ps
module acf_top #(
  parameter int SETTLE_CYC = acf_pkg::SETTLE_CYC,
  parameter int FIFO_DEPTH = acf_pkg::FIFO_DEPTH
) (
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic [1:0]                    gen_tw_wr,
  input  wire logic [1:0][31:0]              gen_tw,
  input  wire logic [1:0][1:0]               grp_src,
  input  wire logic [1:0]                    os_sel_32x,
  input  wire logic [1:0]                    clk_out_sel,
  input  wire logic [5:0][4:0]               ch_div,
  input  wire logic [5:0]                    ch_active,
  input  wire logic [1:0]                    sw_sync,
  input  wire logic [1:0]                    sync_ext_sel,
  input  wire logic                          ext_clk_in,
  input  wire logic                          ext_sync_in,
  input  wire logic                          twos_comp,
  input  wire logic [1:0]                    in_mode,
  input  wire logic [1:0]                    range_sel,
  input  wire logic [5:0]                    adc_valid,
  input  wire logic [5:0][15:0]              adc_data,
  input  wire logic [acf_pkg::CNT_W-1:0]     fifo_thresh,
  input  wire logic [4:0]                    irq_en,
  input  wire logic [4:0]                    flag_clr,
  input  wire logic                          host_rd,
  input  wire logic [1:0]                    dma_start,
  input  wire logic [1:0]                    dma_demand,
  input  wire logic [1:0][acf_pkg::CNT_W-1:0] dma_len,
  input  wire logic                          bm_ack,
  output logic [5:0]                         conv_start,
  output logic                               clk_out,
  output logic                               sync_out,
  output logic [1:0]                         running,
  output logic [1:0]                         in_mode_out,
  output logic [1:0]                         range_out,
  output logic [31:0]                        rd_data,
  output logic                               rd_valid,
  output logic [acf_pkg::CNT_W-1:0]          fifo_level,
  output logic [4:0]                         flags,
  output logic                               irq,
  output logic                               overflow,
  output logic                               bm_req,
  output logic                               bm_chan,
  output logic [31:0]                        bm_data
);
  localparam int CW  = acf_pkg::CNT_W;
  localparam int PAD = acf_pkg::HOST_W - acf_pkg::WORD_W;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_HOST  = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_SEND  = 4'b1000
  } acf_state_t;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // Rate sources
  // ----------------------------------------------------------------------
  logic [1:0] gen_tick;
  logic [1:0] settle_evt;
  logic       ext_clk_q;
  logic       ext_sync_q;
  logic       ext_tick;
  logic       sync_rise;
  logic       out_tick;
  logic [1:0] src_tick;

  for (genvar g = 0; g < acf_pkg::NGEN; g++) begin : g_gen
    acf_rate_gen #(.SETTLE_CYC(SETTLE_CYC)) u_gen (
      .clock      (clock),
      .rst_n      (rst_n),
      .tw_wr      (gen_tw_wr[g]),
      .tw_in      (gen_tw[g]),
      .tick       (gen_tick[g]),
      .settle_done(settle_evt[g])
    );
  end

  function automatic logic pick(input logic [1:0] sel, input logic [1:0] gt,
                                input logic et);
    case (sel)
      acf_pkg::SRC_GEN0: pick = gt[0];
      acf_pkg::SRC_GEN1: pick = gt[1];
      default:           pick = et;
    endcase
  endfunction : pick

  // The external clock is sampled, so it must not exceed half the clock rate.
  assign ext_tick  = ext_clk_in && !ext_clk_q;
  assign sync_rise = ext_sync_in && !ext_sync_q;
  assign out_tick  = pick(clk_out_sel, gen_tick, ext_tick);
  always_comb begin
    for (int g = 0; g < acf_pkg::NGRP; g++) begin
      src_tick[g] = pick(grp_src[g], gen_tick, ext_tick);
    end
  end

  // One pulse per source tick keeps the downstream board at the same rate.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_q  <= 1'b0;
      ext_sync_q <= 1'b0;
      clk_out    <= 1'b0;
    end else begin
      ext_clk_q  <= ext_clk_in;
      ext_sync_q <= ext_sync_in;
      clk_out    <= out_tick;
    end
  end

  // ----------------------------------------------------------------------
  // Group sync and oversampling prescale
  // ----------------------------------------------------------------------
  logic [1:0]      grp_sync;
  logic [1:0]      grp_tick;
  logic [1:0][2:0] pre_reg;
  logic [1:0][2:0] pre_lim;

  always_comb begin
    for (int g = 0; g < acf_pkg::NGRP; g++) begin
      grp_sync[g] = sw_sync[g] || (sync_ext_sel[g] && sync_rise);
      pre_lim[g]  = os_sel_32x[g] ? acf_pkg::OS32_LIM : acf_pkg::OS16_LIM;
      grp_tick[g] = running[g] && !grp_sync[g] && src_tick[g]
                    && pre_reg[g] == pre_lim[g];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg  <= '0;
      running  <= 2'h0;
      sync_out <= 1'b0;
    end else begin
      sync_out <= |grp_sync;
      for (int g = 0; g < acf_pkg::NGRP; g++) begin
        if (grp_sync[g]) begin
          pre_reg[g] <= 3'h0;
          running[g] <= 1'b1;
        end else if (running[g] && src_tick[g]) begin
          pre_reg[g] <= grp_tick[g] ? 3'h0 : pre_reg[g] + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel divide and capture
  // ----------------------------------------------------------------------
  logic [5:0][4:0]  div_reg;
  logic [5:0][4:0]  div_lim;
  logic [5:0]       chan_tick;
  logic [5:0]       pend_v;
  logic [5:0][15:0] pend_d;
  logic [5:0]       take;
  logic [2:0]       sel;
  acf_fifo_if #(.W(acf_pkg::WORD_W), .CW(CW)) fif ();

  always_comb begin
    for (int c = 0; c < acf_pkg::NCH; c++) begin
      if (ch_div[c] < acf_pkg::DIV_MIN) div_lim[c] = 5'h00;
      else if (ch_div[c] > acf_pkg::DIV_MAX) div_lim[c] = acf_pkg::DIV_MAX - 5'h01;
      else div_lim[c] = ch_div[c] - 5'h01;
      chan_tick[c] = grp_tick[c / acf_pkg::GRP_SIZE]
                     && div_reg[c] == div_lim[c];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg    <= '0;
      conv_start <= 6'h00;
    end else begin
      conv_start <= chan_tick & ch_active;
      for (int c = 0; c < acf_pkg::NCH; c++) begin
        if (grp_sync[c / acf_pkg::GRP_SIZE]) div_reg[c] <= 5'h00;
        else if (grp_tick[c / acf_pkg::GRP_SIZE])
          div_reg[c] <= chan_tick[c] ? 5'h00 : div_reg[c] + 5'h01;
      end
    end
  end

  // The lowest pending channel goes first; each channel holds one word.
  always_comb begin
    sel = 3'h0;
    for (int c = acf_pkg::NCH - 1; c >= 0; c--) begin
      if (pend_v[c]) sel = 3'(c);
    end
    take = 6'h00;
    take[sel] = fif.push_ready && pend_v[sel];
  end
  assign fif.push_valid = |pend_v;
  assign fif.push_word  = {sel, pend_d[sel]};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_v   <= 6'h00;
      pend_d   <= '0;
      overflow <= 1'b0;
    end else begin
      for (int c = 0; c < acf_pkg::NCH; c++) begin
        if (adc_valid[c] && ch_active[c]) begin
          if (pend_v[c] && !take[c]) overflow <= 1'b1;
          pend_v[c] <= 1'b1;
          pend_d[c] <= twos_comp ? {~adc_data[c][15], adc_data[c][14:0]}
                                 : adc_data[c];
        end else if (take[c]) begin
          pend_v[c] <= 1'b0;
        end
      end
    end
  end

  acf_sample_fifo #(.DEPTH(FIFO_DEPTH), .W(acf_pkg::WORD_W), .CW(CW)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .fp   (fif.store)
  );

  // ----------------------------------------------------------------------
  // Host reads and DMA master
  // ----------------------------------------------------------------------
  acf_state_t           state;
  logic [1:0]           busy;
  logic [1:0]           burst;
  logic [1:0][CW-1:0]   rem;
  logic [1:0]           dma_go;
  logic                 go_chan;
  logic [1:0]           dma_done;
  logic                 host_go;

  always_comb begin
    for (int d = 0; d < 2; d++) begin
      dma_go[d] = busy[d] && fif.level != '0 && (dma_demand[d] || burst[d]
                  || fif.level >= rem[d]);
    end
    go_chan = !dma_go[0];
    host_go = state == ST_IDLE && host_rd;
  end
  assign fif.pop_req = host_go ? fif.level != '0
                              : state == ST_IDLE && |dma_go;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      busy     <= 2'h0;
      burst    <= 2'h0;
      rem      <= '0;
      dma_done <= 2'h0;
      rd_valid <= 1'b0;
      rd_data  <= 32'h0;
      bm_req   <= 1'b0;
      bm_chan  <= 1'b0;
      bm_data  <= 32'h0;
    end else begin
      dma_done <= 2'h0;
      rd_valid <= 1'b0;
      for (int d = 0; d < 2; d++) begin
        if (dma_start[d] && !busy[d]) begin
          busy[d]  <= dma_len[d] != '0;
          dma_done[d] <= dma_len[d] == '0;
          burst[d] <= 1'b0;
          rem[d]   <= dma_len[d];
        end
      end
      case (state)
        ST_IDLE: begin
          if (host_go) state <= ST_HOST;
          else if (|dma_go) begin
            state          <= ST_FETCH;
            bm_chan        <= go_chan;
            burst[go_chan] <= 1'b1;
          end
        end
        ST_HOST: begin
          rd_valid <= 1'b1;
          rd_data  <= fif.pop_valid ? {PAD'(0), fif.pop_word} : 32'h0;
          state    <= ST_IDLE;
        end
        ST_FETCH: begin
          bm_req  <= 1'b1;
          bm_data <= {PAD'(0), fif.pop_word};
          state   <= ST_SEND;
        end
        ST_SEND: begin
          if (bm_ack) begin
            bm_req       <= 1'b0;
            rem[bm_chan] <= rem[bm_chan] - CW'(1);
            if (rem[bm_chan] == CW'(1)) begin
              busy[bm_chan]     <= 1'b0;
              burst[bm_chan]    <= 1'b0;
              dma_done[bm_chan] <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status flags, interrupt and front-end controls
  // ----------------------------------------------------------------------
  logic [4:0] flag_set;
  assign flag_set = {dma_done, settle_evt, fif.level > fifo_thresh};

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags       <= 5'h00;
      irq         <= 1'b0;
      fifo_level  <= '0;
      in_mode_out <= 2'h0;
      range_out   <= 2'h0;
    end else begin
      flags       <= (flags & ~flag_clr) | flag_set;
      irq         <= |(flags & irq_en);
      fifo_level  <= fif.level;
      in_mode_out <= in_mode;
      range_out   <= range_sel;
    end
  end

  a_clk_follow: assert property (out_tick |=> clk_out)
    else $error("clock output missed a source tick");
  a_sync_out: assert property (sw_sync[0] |=> sync_out)
    else $error("sync output missed a group sync");
  a_prescale: assert property (grp_tick[0] |=> !grp_tick[0] [*3])
    else $error("group rate faster than prescale allows");
  a_inactive: assert property ((conv_start & ~$past(ch_active)) == 6'h00)
    else $error("conversion on inactive channel");
  a_tag_index: assert property (fif.push_valid |->
    pend_v[fif.push_word[18:16]] && (pend_v
    & ((6'h01 << fif.push_word[18:16]) - 6'h01)) == 6'h00)
    else $error("tag is not the lowest pending channel");
  a_thr_flag: assert property (fif.level > fifo_thresh |=> flags[0])
    else $error("threshold flag not set");
  a_irq_merge: assert property (|(flags & irq_en) |=> irq)
    else $error("interrupt not raised");
  a_host_read: assert property (host_go |-> ##2 rd_valid)
    else $error("host read answer late");
  a_bm_hold: assert property (bm_req && !bm_ack |=> bm_req && $stable(bm_data))
    else $error("bus master request dropped");
  c_host_read: cover property (host_go && fif.level != '0 ##2 rd_valid);
  c_dma_done: cover property (bm_req && bm_ack ##1 |dma_done);
  c_ext_sync: cover property (sync_rise && sync_ext_sel[0]);
  c_threshold: cover property ($rose(flags[0]));
endmodule : acf_top

// ---- test/acf_adc_model.sv ----
// Converter model: answers every start pulse with one sample a cycle later.
`timescale 1ns/1ps
module acf_adc_model (
  input  wire logic             clock,
  input  wire logic [5:0]       conv_start,
  output logic      [5:0]       adc_valid,
  output logic      [5:0][15:0] adc_data
);
  // Between strobes the data lines toggle, so a stale sample is never mistaken
  // for a fresh one.
  always_ff @(posedge clock) begin
    adc_valid <= conv_start;
    for (int c = 0; c < 6; c++) begin
      adc_data[c] <= conv_start[c] ? 16'hA5A0 + 16'(c) : ~adc_data[c];
    end
  end
endmodule : acf_adc_model

// ---- test/tb.sv ----
// Self-checking bench for the sample clocking and tagged buffer block.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  $display("unexpected %s exp %0h got %0h", nm, ex, gt); num_errors++; end end
module tb;
  logic             clock = 0, nrst = 0, ext_run = 0, ext_clk_in = 0;
  logic             ext_sync_in = 0, twos_comp = 0, host_rd = 0, bm_ack = 0;
  logic [1:0]       gen_tw_wr = '0, os_sel_32x = '0, clk_out_sel = '0;
  logic [1:0]       sw_sync = '0, sync_ext_sel = '0, dma_start = '0;
  logic [1:0]       in_mode = 2'h2, range_sel = 2'h3, dma_demand = '0;
  logic [1:0][31:0] gen_tw = '0;
  logic [1:0][1:0]  grp_src = {2'h2, 2'h2};
  logic [1:0][16:0] dma_len = '0;
  logic [5:0][4:0]  ch_div = {6{5'h01}};
  logic [5:0]       ch_active = 6'h05, conv_start, adc_valid;
  logic [5:0][15:0] adc_data;
  logic [16:0]      fifo_thresh = 17'h00002, fifo_level;
  logic [4:0]       irq_en = 5'h01, flag_clr = '0, flags;
  logic [31:0]      rd_data, bm_data;
  logic [1:0]       running, in_mode_out, range_out;
  logic             clk_out, sync_out, rd_valid, irq, overflow, bm_req, bm_chan;
  int               num_errors = 0, checks = 0, cyc = 0;

  acf_top #(.SETTLE_CYC(50), .FIFO_DEPTH(16)) uut (.*);
  acf_adc_model adc (.clock(clock), .conv_start(conv_start),
                     .adc_valid(adc_valid), .adc_data(adc_data));

  always #20 clock = ~clock;
  always @(negedge clock) if (ext_run) ext_clk_in <= ~ext_clk_in;
  // --------------------------------------------------------------------------
  // Hang guard: the whole run needs well under two thousand cycles.
  // --------------------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic t_clkout(input logic [1:0] sel, input int len, lo, hi);
    int n = 0;
    clk_out_sel = sel;
    ext_run = (sel == 2'h2);
    repeat (len) @(negedge clock) n += clk_out;
    ext_run = 0;
    `CHK("clk_out", 1'b1, n >= lo && n <= hi)
  endtask : t_clkout

  task automatic t_settle();
    gen_tw[0] = acf_pkg::TW_MIN;
    gen_tw_wr = 2'h1;
    @(negedge clock) gen_tw_wr = 2'h0;
    repeat (40) @(negedge clock);
    `CHK("settle_early", 1'b0, flags[1])
    repeat (20) @(negedge clock);
    `CHK("settle_done", 1'b1, flags[1])
  endtask : t_settle

  task automatic t_sync();
    sw_sync = 2'h1;
    @(negedge clock) sw_sync = 2'h0;
    for (int i = 0; i < 3 && sync_out !== 1'b1; i++) @(negedge clock);
    `CHK("sync_out", 1'b1, sync_out)
    @(negedge clock) `CHK("running", 2'h1, running)
  endtask : t_sync

  // Channels 0 and 2 convert on the same tick, so tags must alternate.
  task automatic t_capture(input logic tc);
    logic [15:0] d;
    logic [2:0]  t;
    twos_comp = tc;
    t_sync();
    ext_run = 1;
    for (int i = 0; i < 400 && fifo_level < 17'h4; i++) @(negedge clock);
    ext_run = 0;
    repeat (4) @(negedge clock);
    `CHK("level", 1'b1, fifo_level >= 17'h4)
    `CHK("thr_flag", 1'b1, flags[0])
    `CHK("irq", 1'b1, irq)
    `CHK("overflow", 1'b0, overflow)
    for (int n = 0; n < 16 && fifo_level != 0; n++) begin
      t = n[0] ? 3'h2 : 3'h0;
      d = 16'hA5A0 + 16'(t);
      d[15] = d[15] ^ tc;
      host_rd = 1'b1;
      @(negedge clock) host_rd = 1'b0;
      @(negedge clock);
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rd_data", {13'h0, t, d}, rd_data)
    end
    @(negedge clock) `CHK("drained", 17'h0, fifo_level)
    flag_clr = 5'h01;
    @(negedge clock) flag_clr = 5'h00;
    repeat (2) @(negedge clock);
    `CHK("irq_clr", 1'b0, irq)
  endtask : t_capture

  // Channel 2 divides by three at x32, so it converts on every third tick.
  task automatic t_harm();
    int n0 = 0, n2 = 0;
    ch_div[2] = 5'h03;
    os_sel_32x = 2'h1;
    t_sync();
    ext_run = 1;
    for (int i = 0; i < 112; i++) begin
      @(negedge clock) if (i == 103) ext_run = 0;
      n0 += conv_start[0];
      n2 += conv_start[2];
    end
    repeat (4) @(negedge clock);
    `CHK("harm_rate", 1'b1, n0 >= 5 && n0 <= 7)
    `CHK("harm_div", n0 / 3, n2)
    `CHK("harm_level", 17'(n0 + n2), fifo_level)
    for (int n = 0; n < 16 && fifo_level != 0; n++) begin
      host_rd = 1'b1;
      @(negedge clock) host_rd = 1'b0;
      @(negedge clock);
    end
    `CHK("harm_drain", 17'h0, fifo_level)
    ch_div[2] = 5'h01;
    os_sel_32x = 2'h0;
  endtask : t_harm

  // External sync restarts group 0; channel 1 then moves the words on demand.
  task automatic t_dma();
    logic [15:0] d;
    logic [2:0]  t;
    int          lv;
    sync_ext_sel = 2'h1;
    ext_sync_in = 1'b1;
    @(negedge clock) ext_sync_in = 1'b0;
    sync_ext_sel = 2'h0;
    `CHK("ext_sync", 1'b1, sync_out)
    ext_run = 1;
    for (int i = 0; i < 400 && fifo_level < 17'h2; i++) @(negedge clock);
    ext_run = 0;
    repeat (8) @(negedge clock);
    lv = int'(fifo_level);
    `CHK("dma_words", 1'b1, lv >= 2)
    dma_len[1] = fifo_level;
    dma_demand = 2'h2;
    dma_start = 2'h2;
    @(negedge clock) dma_start = 2'h0;
    for (int n = 0; n < lv; n++) begin
      for (int i = 0; i < 8 && bm_req !== 1'b1; i++) @(negedge clock);
      t = n[0] ? 3'h2 : 3'h0;
      d = 16'hA5A0 + 16'(t);
      d[15] = d[15] ^ twos_comp;
      `CHK("bm_req", 1'b1, bm_req)
      `CHK("bm_chan", 1'b1, bm_chan)
      `CHK("bm_data", {13'h0, t, d}, bm_data)
      bm_ack = 1'b1;
      @(negedge clock) bm_ack = 1'b0;
    end
    repeat (2) @(negedge clock);
    `CHK("dma_done", 1'b1, flags[4])
    `CHK("dma_empty", 17'h0, fifo_level)
  endtask : t_dma

  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("in_mode_out", 2'h2, in_mode_out)
    `CHK("range_out", 2'h3, range_out)
    t_clkout(2'h2, 40, 19, 21);
    t_settle();
    t_clkout(2'h0, 104, 9, 11);
    t_capture(1'b0);
    t_capture(1'b1);
    t_harm();
    t_dma();
    wrap_up();
  end
endmodule : tb
